/* File: cmp_ctrl_sva.sv */
// Port-level assertions for the comparator control block.
`timescale 1ns/100ps
`default_nettype none
module cmp_ctrl_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [2:0] irq_o,
    input wire logic [2:0] conv_trigger_o,
    input wire logic capture_in_o,
    input wire logic capture_route_o,
    input wire logic [2:0] cmp_enable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    irq_flag_a: assert property ((irq_o & ~conv_trigger_o) == 3'h0)
        else $error("interrupt request without a pending flag");
    route_off_a: assert property (
        !capture_route_o [*3] |-> !capture_in_o)
        else $error("capture input active with routing off");
    trig_enabled_a: assert property (
        (conv_trigger_o & ~$past(conv_trigger_o) & ~cmp_enable_o) == 3'h0)
        else $error("event flag raised on a disabled comparator");
    wr_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
        s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
        else $error("write response not on time");
    wr_err_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
        s_axi_wvalid_i && s_axi_wready_o && s_axi_awaddr_i > 32'h13
        |-> ##2 s_axi_bresp_o == 2'h2)
        else $error("unmapped write not refused");
    rd_err_a: assert property (s_axi_arvalid_i && s_axi_arready_o &&
        s_axi_araddr_i > 32'h13 |=> s_axi_rvalid_o &&
        s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
        else $error("unmapped read not refused");
    resp_busy_a: assert property (s_axi_bvalid_o |->
        !s_axi_awready_o && !s_axi_wready_o)
        else $error("write accepted while response pending");
    b_once_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
        !s_axi_bvalid_o)
        else $error("write response repeated");
    r_once_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
        !s_axi_rvalid_o)
        else $error("read response repeated");
endmodule
bind triple_comparator_control cmp_ctrl_sva u_sva (.*);
`default_nettype wire

/* File: cmp_front_model.sv */
// Behavioural comparator cores and sampling clock sources.
`timescale 1ns/100ps
`default_nettype none
module cmp_front_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] above_i,
    output logic io_clk_o,
    output logic pll_clk_o,
    output logic [2:0] cmp_raw_o,
    input wire logic capture_in_i,
    input wire logic capture_irq_mask_i,
    output logic capture_irq_o
);
    logic [3:0] div;
    logic capture_prev;
    always_ff @(posedge clk_i) begin
        div <= rst_i ? 4'h0 : div + 4'h1;
    end
    // Both clocks stay well below a quarter of clk_i so synced edges are seen.
    assign io_clk_o = div[2];
    assign pll_clk_o = div[3];
    assign cmp_raw_o = above_i;
    // Timer side: a routed capture edge raises its interrupt only while the
    // capture interrupt mask is set; the routing bit alone is not enough.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_prev <= 1'b0;
            capture_irq_o <= 1'b0;
        end else begin
            capture_prev <= capture_in_i;
            if (capture_in_i & ~capture_prev & capture_irq_mask_i) begin
                capture_irq_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: cmp_pkg.sv */
// Package with register map, field layout and types of the comparator block.
package cmp_pkg;
    localparam int NUM_CMP = 3;
    localparam logic [31:0] CTRL0_ADDR = 32'h0000_0000;
    localparam logic [31:0] CTRL1_ADDR = 32'h0000_0004;
    localparam logic [31:0] CTRL2_ADDR = 32'h0000_0008;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_000c;
    localparam logic [31:0] VECTOR_ADDR = 32'h0000_0010;
    localparam int ENABLE_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int SENSE_HI_BIT = 5;
    localparam int SENSE_LO_BIT = 4;
    localparam int ROUTE_BIT = 3;
    localparam int NEGSEL_HI = 2;
    localparam int NEGSEL_LO = 0;
    localparam int FLAG_LO_BIT = 4;
    localparam int CLK_SEL_BIT = 3;
    localparam int OUT_LO_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL0_MASK = 8'hf7;
    localparam logic [7:0] CTRL1_MASK = 8'hff;
    localparam logic [1:0] SENSE_TOGGLE = 2'h0;
    localparam logic [1:0] SENSE_RSVD = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;
    localparam logic [2:0] NEG_DIV640 = 3'h0;
    localparam logic [2:0] NEG_DIV320 = 3'h1;
    localparam logic [2:0] NEG_DIV213 = 3'h2;
    localparam logic [2:0] NEG_DIV160 = 3'h3;
    localparam logic [2:0] NEG_PIN = 3'h4;
    localparam logic [2:0] NEG_DAC = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic enable;
        logic irq_enable;
        logic [1:0] sense;
        logic capture_route;
        logic [2:0] negative_input_selector;
    } cmp_ctrl_s;
endpackage

/* File: triple_comparator_control.sv */
// Control, sampling and event flag logic around three clocked comparators.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Output high when positive input above selected reference
// - Sample every comparator on each falling I/O edge
// - Separate interrupt request line per comparator
// - Control bit 7 turns comparator on
// - Control bit 6 gates interrupt request
// - Bits 5:4 choose toggle, fall or rise
// - Bits 2:0 choose negative input source
// - Event sets status flag bit 6,5,4
// - Vector acknowledge clears flag when irq enabled
// - Writing one clears flag, zero keeps it
// - Flags offered as converter start triggers
// - Bit 3 routes comparator 1 to capture
// - Capture edge select picks rising or falling
// - Routing off leaves capture path disconnected
// - Status bit 3 selects PLL derived clock
// - Cleared clock select uses ordinary I/O clock
// - Status bits 2:0 show live outputs
module triple_comparator_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [2:0] cmp_raw_i,
    input wire logic io_clk_i,
    input wire logic pll_clk_i,
    input wire logic timer_capture_edge_select_i,
    output logic [2:0] irq_o,
    output logic [2:0] conv_trigger_o,
    output logic capture_in_o,
    output logic capture_route_o,
    output logic [2:0] cmp_enable_o,
    output logic [8:0] negative_input_selector_o,
    output logic cmp_clock_pll_select_o
);
    import cmp_pkg::*;

    cmp_ctrl_s ctrl [NUM_CMP];
    logic [NUM_CMP-1:0] flag;
    logic clk_sel;
    logic [NUM_CMP-1:0] raw_s1, raw_s2, cmp_out, cmp_prev;
    logic io_s1, io_s2, io_d, pll_s1, pll_s2, pll_d;
    logic sample_strobe;
    logic [NUM_CMP-1:0] event_hit;
    logic [31:0] aw_addr, w_data;
    logic aw_held, w_held;
    logic wr_go;
    logic [NUM_CMP-1:0] wr_clear, vec_clear;
    logic wr_ok;

    // ------------------------------------------------------------------
    // Synchronise comparator results and the sampling clocks.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raw_s1 <= '0;
            raw_s2 <= '0;
            io_s1 <= 1'b0;
            io_s2 <= 1'b0;
            io_d <= 1'b0;
            pll_s1 <= 1'b0;
            pll_s2 <= 1'b0;
            pll_d <= 1'b0;
        end else begin
            raw_s1 <= cmp_raw_i;
            raw_s2 <= raw_s1;
            io_s1 <= io_clk_i;
            io_s2 <= io_s1;
            io_d <= io_s2;
            pll_s1 <= pll_clk_i;
            pll_s2 <= pll_s1;
            pll_d <= pll_s2;
        end
    end

    // Falling edge of whichever comparator clock is chosen; either clock
    // must stay below a quarter of clk_i for this to see every edge.
    always_comb begin
        if (clk_sel) begin
            sample_strobe = pll_d & ~pll_s2;
        end else begin
            sample_strobe = io_d & ~io_s2;
        end
    end

    // ------------------------------------------------------------------
    // Registered comparator outputs and edge detection.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_out <= '0;
            cmp_prev <= '0;
        end else if (sample_strobe) begin
            cmp_prev <= cmp_out;
            for (int i = 0; i < NUM_CMP; i++) begin
                // The analog core reports positive above negative as one.
                cmp_out[i] <= raw_s2[i] & ctrl[i].enable;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            event_hit[i] = 1'b0;
            if (ctrl[i].enable) begin
                unique case (ctrl[i].sense)
                    SENSE_TOGGLE: event_hit[i] = cmp_out[i] ^ cmp_prev[i];
                    SENSE_RSVD: event_hit[i] = 1'b0;
                    SENSE_FALL: event_hit[i] = cmp_prev[i] & ~cmp_out[i];
                    SENSE_RISE: event_hit[i] = cmp_out[i] & ~cmp_prev[i];
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel.
    // ------------------------------------------------------------------
    assign wr_go = aw_held & w_held & ~s_axi_bvalid_o;
    assign wr_ok = (aw_addr == CTRL0_ADDR) | (aw_addr == CTRL1_ADDR) |
                   (aw_addr == CTRL2_ADDR) | (aw_addr == STATUS_ADDR) |
                   (aw_addr == VECTOR_ADDR);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            s_axi_awready_o <= 1'b1;
        end else if (s_axi_awvalid_i & s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr_i[31:2], 2'b00};
            s_axi_awready_o <= 1'b0;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end else if (~aw_held & ~s_axi_bvalid_o) begin
            s_axi_awready_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_held <= 1'b0;
            w_data <= '0;
            s_axi_wready_o <= 1'b1;
        end else if (s_axi_wvalid_i & s_axi_wready_o) begin
            w_held <= 1'b1;
            // Only the low byte carries register bits.
            w_data <= s_axi_wstrb_i[0] ? s_axi_wdata_i : 32'h0000_0000;
            s_axi_wready_o <= 1'b0;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end else if (~w_held & ~s_axi_bvalid_o) begin
            s_axi_wready_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                ctrl[i] <= CTRL_RESET;
            end
        end else if (wr_go) begin
            if (aw_addr == CTRL0_ADDR) begin
                ctrl[0] <= w_data[7:0] & CTRL0_MASK;
            end
            if (aw_addr == CTRL1_ADDR) begin
                ctrl[1] <= w_data[7:0] & CTRL1_MASK;
            end
            if (aw_addr == CTRL2_ADDR) begin
                ctrl[2] <= w_data[7:0] & CTRL0_MASK;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sel <= 1'b0;
        end else if (wr_go & (aw_addr == STATUS_ADDR)) begin
            clk_sel <= w_data[CLK_SEL_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Event flags: a new event wins over any clear in the same cycle.
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            wr_clear[i] = wr_go & (aw_addr == STATUS_ADDR) &
                          w_data[FLAG_LO_BIT + i];
            vec_clear[i] = wr_go & (aw_addr == VECTOR_ADDR) &
                           w_data[i] & ctrl[i].irq_enable;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag <= '0;
        end else begin
            for (int i = 0; i < NUM_CMP; i++) begin
                if (sample_strobe & event_hit[i]) begin
                    flag[i] <= 1'b1;
                end else if (wr_clear[i] | vec_clear[i]) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs to the processor, converters, timer and analog cores.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= '0;
            conv_trigger_o <= '0;
            capture_in_o <= 1'b0;
            capture_route_o <= 1'b0;
            cmp_enable_o <= '0;
            negative_input_selector_o <= '0;
            cmp_clock_pll_select_o <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CMP; i++) begin
                irq_o[i] <= flag[i] & ctrl[i].irq_enable;
                conv_trigger_o[i] <= flag[i];
                cmp_enable_o[i] <= ctrl[i].enable;
                negative_input_selector_o[i*3 +: 3] <=
                    ctrl[i].negative_input_selector;
            end
            // The timer's own edge select sees the inverted level when it
            // asks for falling edges, so it always captures on a rise here.
            if (ctrl[1].capture_route) begin
                capture_in_o <= cmp_out[1] ^ ~timer_capture_edge_select_i;
            end else begin
                capture_in_o <= 1'b0;
            end
            capture_route_o <= ctrl[1].capture_route;
            cmp_clock_pll_select_o <= clk_sel;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arvalid_i & s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= RESP_OKAY;
            unique case ({s_axi_araddr_i[31:2], 2'b00})
                CTRL0_ADDR: s_axi_rdata_o <= {24'h000000, ctrl[0]};
                CTRL1_ADDR: s_axi_rdata_o <= {24'h000000, ctrl[1]};
                CTRL2_ADDR: s_axi_rdata_o <= {24'h000000, ctrl[2]};
                STATUS_ADDR: s_axi_rdata_o <= {24'h000000, 1'b0, flag,
                                               clk_sel, cmp_out};
                VECTOR_ADDR: s_axi_rdata_o <= 32'h0000_0000;
                default: begin
                    s_axi_rdata_o <= 32'h0000_0000;
                    s_axi_rresp_o <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_o & s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end
endmodule

`default_nettype wire

/* File: triple_comparator_control_tb.sv */
// Self-checking testbench for the comparator control block.
`timescale 1ns/100ps
`default_nettype none
module triple_comparator_control_tb;
    import cmp_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, rise, fall;
    logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic timer_capture_edge_select_i = 1'b1, timer_capture_irq_mask = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, io_clk_i, pll_clk_i, capture_in_o, capture_route_o;
    logic cmp_clock_pll_select_o, capture_irq;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic [31:0] s_axi_rdata_o, d;
    logic [2:0] cmp_raw_i, irq_o, conv_trigger_o, cmp_enable_o, above = 3'h0;
    logic [8:0] negative_input_selector_o;
    logic [1:0] codes [4] = '{SENSE_TOGGLE, SENSE_FALL, SENSE_RISE, SENSE_RSVD};
    int miscompares = 0, samples_checked = 0;
    triple_comparator_control dut (.*);
    cmp_front_model model (.clk_i(clk_i), .rst_i(rst_i), .above_i(above),
        .io_clk_o(io_clk_i), .pll_clk_o(pll_clk_i), .cmp_raw_o(cmp_raw_i),
        .capture_in_i(capture_in_o),
        .capture_irq_mask_i(timer_capture_irq_mask),
        .capture_irq_o(capture_irq));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        fork
            begin
                do @(negedge clk_i); while (!s_axi_awready_o);
                @(posedge clk_i) s_axi_awvalid_i <= 1'b0;
            end
            begin
                do @(negedge clk_i); while (!s_axi_wready_o);
                @(posedge clk_i) s_axi_wvalid_i <= 1'b0;
            end
        join
        do @(negedge clk_i); while (!s_axi_bvalid_o);
        resp = s_axi_bresp_o;
        @(posedge clk_i) s_axi_bready_i <= 1'b0;
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do @(negedge clk_i); while (!s_axi_arready_o);
        @(posedge clk_i) s_axi_arvalid_i <= 1'b0;
        do @(negedge clk_i); while (!s_axi_rvalid_o);
        d = s_axi_rdata_o;
        resp = s_axi_rresp_o;
        @(posedge clk_i) s_axi_rready_i <= 1'b0;
        chk(d, exp);
    endtask
    task automatic settle();
        repeat (40) @(posedge clk_i);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) rc(CTRL0_ADDR + 32'(4 * i), 32'h0);
        wr(CTRL0_ADDR, 32'hff);
        wr(CTRL1_ADDR, 32'hff);
        wr(CTRL2_ADDR, 32'hff);
        rc(CTRL0_ADDR, 32'hf7);
        rc(CTRL1_ADDR, 32'hff);
        chk(32'(cmp_enable_o), 32'h7);
        chk(32'(capture_route_o), 32'h1);
        for (int n = 0; n < 6; n++) begin
            wr(CTRL0_ADDR, 32'(n));
            // The selector output register updates on the edge the write
            // task ends on, so look after it has settled.
            @(negedge clk_i);
            chk(32'(negative_input_selector_o[2:0]), 32'(n));
        end
        chk(32'(negative_input_selector_o), 32'h1fd);
        wr(CTRL1_ADDR, 32'h0);
        // A write with the low byte lane off stores zeros.
        s_axi_wstrb_i <= 4'h0;
        wr(CTRL2_ADDR, 32'hff);
        s_axi_wstrb_i <= 4'hf;
        rc(CTRL2_ADDR, 32'h0);
        rc(32'h20, 32'h0);
        chk(32'(resp), 32'(RESP_SLVERR));
        wr(32'h20, 32'h1);
        chk(32'(resp), 32'(RESP_SLVERR));
        $display("test registers done");
        foreach (codes[i]) begin
            wr(CTRL0_ADDR, {24'h0, 2'b10, codes[i], 4'h0});
            settle();
            wr(STATUS_ADDR, 32'h70);
            above[0] <= 1'b1;
            settle();
            rise = codes[i] == SENSE_TOGGLE || codes[i] == SENSE_RISE;
            fall = codes[i] == SENSE_TOGGLE || codes[i] == SENSE_FALL;
            rc(STATUS_ADDR, {27'h0, rise, 4'h1});
            chk(32'(conv_trigger_o), {31'h0, rise});
            chk(32'(irq_o), 32'h0);
            wr(STATUS_ADDR, 32'h70);
            above[0] <= 1'b0;
            settle();
            rc(STATUS_ADDR, {27'h0, fall, 4'h0});
        end
        $display("test sensitivity done");
        wr(CTRL0_ADDR, 32'h0);
        wr(CTRL1_ADDR, 32'h80);
        settle();
        above[1] <= 1'b1;
        settle();
        wr(STATUS_ADDR, 32'h0);
        rc(STATUS_ADDR, 32'h22);
        wr(VECTOR_ADDR, 32'h2);
        rc(STATUS_ADDR, 32'h22);
        chk(32'(irq_o), 32'h0);
        chk(32'(conv_trigger_o), 32'h2);
        wr(CTRL1_ADDR, 32'hc0);
        settle();
        chk(32'(irq_o), 32'h2);
        wr(VECTOR_ADDR, 32'h2);
        rc(STATUS_ADDR, 32'h02);
        chk(32'(irq_o), 32'h0);
        $display("test vector done");
        wr(CTRL1_ADDR, 32'h88);
        settle();
        chk(32'(capture_in_o), 32'h1);
        chk(32'(capture_irq), 32'h0);
        timer_capture_edge_select_i <= 1'b0;
        timer_capture_irq_mask <= 1'b1;
        settle();
        chk(32'(capture_in_o), 32'h0);
        above[1] <= 1'b0;
        settle();
        chk(32'(capture_in_o), 32'h1);
        chk(32'(capture_irq), 32'h1);
        wr(CTRL1_ADDR, 32'h80);
        settle();
        chk(32'(capture_in_o), 32'h0);
        wr(STATUS_ADDR, 32'h70);
        above[2] <= 1'b1;
        settle();
        above[2] <= 1'b0;
        settle();
        rc(STATUS_ADDR, 32'h0);
        $display("test capture done");
        wr(STATUS_ADDR, 32'h08);
        rc(STATUS_ADDR, 32'h08);
        chk(32'(cmp_clock_pll_select_o), 32'h1);
        wr(CTRL0_ADDR, 32'h80);
        settle();
        above[0] <= 1'b1;
        settle();
        settle();
        rc(STATUS_ADDR, 32'h19);
        wr(STATUS_ADDR, 32'h70);
        above[0] <= 1'b0;
        settle();
        rc(STATUS_ADDR, 32'h10);
        $display("test clock select done");
        results();
    end
endmodule
`default_nettype wire
